// ---- hdl/content_protect_control_reg.sv ----
// Protection control register, authentication sequencer and video gating
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module content_protect_control_reg
   import cpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic key_fetched,
   input wire logic list_fetched,
   input wire logic link_lost,
   input wire vid_t vid_in,
   output vid_t vid_out,
   output logic authed_reg
);
   reg_wr_t wr;
   logic rd_en;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic wr_hit;
   logic rd_hit;
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic [2:0] pin_prev_reg;
   logic key_rise;
   logic list_rise;
   logic lost;
   logic wr_ctl;
   logic wr_cfg;
   logic [7:0] wd;
   logic eng_rst;
   logic auth_dis;
   logic auth_go;
   logic key_ok_set;
   logic list_ok_set;
   logic enc_always;
   logic enc_eff;
   logic rptr;
   logic key_rdy_set;
   logic advance_list;
   logic auth_en_reg;
   logic key_ok_reg;
   logic list_ok_reg;
   logic encrypt_on_reg;
   logic key_rdy_reg;
   logic list_rdy_reg;
   logic [7:0] cfg_reg;
   logic [7:0] ctl_view;
   auth_state_t state_reg;
   auth_state_t state_next;

   cpc_axil_port u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr(wr),
      .wr_hit(wr_hit),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_hit(rd_hit),
      .rd_data(rd_data)
   );

   // Link status pins: two-stage synchronisers, edge detect after on key and list; link loss is used as a level
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_sync
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               pin_meta_reg[i] <= 1'b0;
               pin_sync_reg[i] <= 1'b0;
               pin_prev_reg[i] <= 1'b0;
            end
            else
            begin
               pin_meta_reg[i] <= (i == 0) ? key_fetched :
                                  (i == 1) ? list_fetched : link_lost;
               pin_sync_reg[i] <= pin_meta_reg[i];
               pin_prev_reg[i] <= pin_sync_reg[i];
            end
         end
      end
   endgenerate

   assign key_rise = pin_sync_reg[0] && !pin_prev_reg[0];
   assign list_rise = pin_sync_reg[1] && !pin_prev_reg[1];
   assign lost = pin_sync_reg[2];

   // Write decode; only byte lane 0 carries the 8-bit registers
   assign wd = wr.data[7:0];
   assign wr_hit = (wr.addr == ADDR_CTL) || (wr.addr == ADDR_CFG) ||
                   (wr.addr == ADDR_STS);
   assign wr_ctl = wr.en && wr.strb[0] && (wr.addr == ADDR_CTL);
   assign wr_cfg = wr.en && wr.strb[0] && (wr.addr == ADDR_CFG);
   assign eng_rst = wr_ctl && wd[B_ENG_RST];
   assign auth_dis = wr_ctl && wd[B_AUTH_DIS];
   assign auth_go = wr_ctl && wd[B_AUTH_EN] && !eng_rst && !auth_dis;
   assign key_ok_set = wr_ctl && wd[B_KEY_OK];
   assign list_ok_set = wr_ctl && wd[B_LIST_OK];
   assign rptr = cfg_reg[B_RPTR];
   assign enc_always = cfg_reg[B_MODE_HI:B_MODE_LO] == ENC_ALWAYS;
   assign enc_eff = enc_always || encrypt_on_reg;
   assign key_rdy_set = (state_reg == A_FETCH) && key_rise &&
                        !lost && !eng_rst && !auth_dis && !auth_go;
   assign advance_list = (state_reg == A_LIST_WAIT) && list_rdy_reg &&
                         list_ok_reg && !lost;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_reg <= CFG_RESET;
      else if (wr_cfg)
         cfg_reg <= wd & CFG_MASK;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         auth_en_reg <= 1'b0;
      else if (eng_rst || auth_dis)
         auth_en_reg <= 1'b0;
      else if (auth_go)
         auth_en_reg <= 1'b1;
   end

   // Authentication sequencer
   always_comb
   begin
      state_next = state_reg;
      if (eng_rst || auth_dis)
         state_next = A_OFF;
      else if (auth_go)
         state_next = A_FETCH;
      else if (lost && state_reg != A_OFF)
         state_next = A_FETCH;
      else
         case (state_reg)
            A_OFF: state_next = A_OFF;
            A_FETCH:
               if (key_rise)
                  state_next = A_KEY_WAIT;
            A_KEY_WAIT:
               if (rptr)
                  state_next = A_LIST_WAIT;
               else if (key_ok_reg)
                  state_next = A_DONE;
            A_LIST_WAIT:
               if (advance_list)
                  state_next = A_DONE;
            A_DONE: state_next = A_DONE;
            default: state_next = A_OFF;
         endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= A_OFF;
         authed_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         authed_reg <= state_next == A_DONE;
      end
   end

   // Software set wins over the hardware clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         key_ok_reg <= 1'b0;
      else if (key_ok_set)
         key_ok_reg <= 1'b1;
      else if (key_rdy_set || eng_rst)
         key_ok_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         list_ok_reg <= 1'b0;
      else if (list_ok_set)
         list_ok_reg <= 1'b1;
      else if (advance_list || eng_rst)
         list_ok_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         key_rdy_reg <= 1'b0;
      else if (key_rdy_set)
         key_rdy_reg <= 1'b1;
      else if (key_ok_set || state_next == A_OFF ||
               state_next == A_FETCH)
         key_rdy_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         list_rdy_reg <= 1'b0;
      else if (state_reg == A_LIST_WAIT && list_rise && !lost)
         list_rdy_reg <= 1'b1;
      else if (state_next != A_LIST_WAIT)
         list_rdy_reg <= 1'b0;
   end

   // Encryption enable; frozen while always-encrypt is selected
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         encrypt_on_reg <= 1'b0;
      else if (wr_ctl && !enc_always)
         encrypt_on_reg <= wd[B_ENC_ON] && !wd[B_ENC_OFF];
   end

   // Pulse bits 7, 3, 1 and reserved bit 6 always read zero
   assign ctl_view = {1'b0, 1'b0, list_ok_reg, key_ok_reg, 1'b0,
                      enc_eff, 1'b0, auth_en_reg};

   always_comb
   begin
      rd_hit = 1'b1;
      rd_data = 32'h0000_0000;
      case (rd_addr)
         ADDR_CTL: rd_data[7:0] = ctl_view;
         ADDR_CFG: rd_data[7:0] = cfg_reg;
         ADDR_STS: rd_data[S_LIST_RDY:S_AUTHED] =
            {list_rdy_reg, key_rdy_reg, authed_reg};
         default: rd_hit = 1'b0;
      endcase
   end

   cpc_video_select u_vid (
      .aclk(aclk),
      .aresetn(aresetn),
      .vid_in(vid_in),
      .enc_en(enc_eff),
      .authed(authed_reg),
      .vid_out(vid_out)
   );

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_eng_rst;
      eng_rst |=> !auth_en_reg && state_reg == A_OFF && !ctl_view[7];
   endproperty
   a_eng_rst: assert property (p_eng_rst)
      else $error("engine reset did not stop authentication");

   property p_list_done;
      advance_list && !eng_rst && !auth_dis && !auth_go
         |=> state_reg == A_DONE && !list_ok_reg ##1 authed_reg;
   endproperty
   a_list_done: assert property (p_list_done)
      else $error("list approval did not finish authentication");

   property p_key_gate;
      state_reg == A_KEY_WAIT && !rptr && !key_ok_reg
         |=> state_reg != A_DONE;
   endproperty
   a_key_gate: assert property (p_key_gate)
      else $error("passed key stage without approval");

   property p_key_clr;
      key_rdy_set && !key_ok_set |=> !key_ok_reg && key_rdy_reg;
   endproperty
   a_key_clr: assert property (p_key_clr)
      else $error("key approval not cleared on key ready");

   property p_key_zero;
      wr_ctl && !wd[B_KEY_OK] && !key_rdy_set && !eng_rst
         |=> key_ok_reg == $past(key_ok_reg);
   endproperty
   a_key_zero: assert property (p_key_zero)
      else $error("writing zero changed key approval");

   property p_enc_off;
      wr_ctl && wd[B_ENC_OFF] && !enc_always && state_reg == A_DONE &&
         !lost && !eng_rst && !auth_dis && !auth_go
         |=> !enc_eff && state_reg == A_DONE ##1 vid_out == $past(vid_in);
   endproperty
   a_enc_off: assert property (p_enc_off)
      else $error("encrypt off lost state or kept encrypting");

   property p_enc_video;
      enc_eff && authed_reg |=>
         vid_out.rgb == ($past(vid_in.rgb) ^ $past(u_vid.ks_reg));
   endproperty
   a_enc_video: assert property (p_enc_video)
      else $error("authenticated video not encrypted");

   property p_blue;
      enc_eff && !authed_reg |=> vid_out.rgb == BLUE_RGB;
   endproperty
   a_blue: assert property (p_blue)
      else $error("blue screen missing");

   property p_pass;
      !enc_eff |=> vid_out == $past(vid_in);
   endproperty
   a_pass: assert property (p_pass)
      else $error("clear video altered");

   property p_always;
      enc_always && wr_ctl |=> ctl_view[B_ENC_ON] &&
         encrypt_on_reg == $past(encrypt_on_reg);
   endproperty
   a_always: assert property (p_always)
      else $error("encrypt enable writable in always mode");

   property p_dis;
      auth_dis |=> !auth_en_reg && state_reg == A_OFF;
   endproperty
   a_dis: assert property (p_dis)
      else $error("disable did not take effect");

   property p_restart;
      auth_go |=> state_reg == A_FETCH && auth_en_reg;
   endproperty
   a_restart: assert property (p_restart)
      else $error("enable did not restart sequencer");

   property p_en_read;
      rd_en && rd_addr == ADDR_CTL
         |=> rvalid && rdata[B_AUTH_EN] == $past(auth_en_reg);
   endproperty
   a_en_read: assert property (p_en_read)
      else $error("bit 0 read does not show enable state");

   property p_mode;
      wr_cfg && wd[B_MODE_HI:B_MODE_LO] == ENC_ALWAYS |=> enc_eff;
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode 10 did not force encryption");

   property p_key_rdy;
      key_rdy_set |=> key_rdy_reg && state_reg == A_KEY_WAIT;
   endproperty
   a_key_rdy: assert property (p_key_rdy)
      else $error("key ready flag not raised");

   property p_rsvd;
      rd_en && rd_addr == ADDR_CTL |=> rdata[B_RSVD] == 1'b0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bit reads one");

   c_direct: cover property (state_reg == A_KEY_WAIT && !rptr
      ##1 state_reg == A_DONE);
   c_repeater: cover property (advance_list ##1 state_reg == A_DONE);
   c_blue: cover property (enc_eff && !authed_reg && vid_in.de);
endmodule : content_protect_control_reg

// ---- hdl/cpc_axil_port.sv ----
// AXI4-Lite slave front end of the protection control block
`timescale 1ns/1ps
module cpc_axil_port
   import cpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output reg_wr_t wr,
   input wire logic wr_hit,
   output logic rd_en,
   output logic [ADDR_W-1:0] rd_addr,
   input wire logic rd_hit,
   input wire logic [31:0] rd_data
);
   logic aw_full_reg;
   logic w_full_reg;
   logic rd_pend_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   // Address and data held until both are in and no response is pending
   assign wr = '{en: aw_full_reg && w_full_reg && !bvalid,
                 addr: waddr_reg, data: wdata_reg, strb: wstrb_reg};
   assign rd_en = rd_pend_reg && !rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         waddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_full_reg <= 1'b1;
            awready <= 1'b0;
            waddr_reg <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_full_reg <= 1'b1;
            wready <= 1'b0;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         if (wr.en)
         begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_pend_reg <= 1'b0;
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
         rd_addr <= '0;
      end
      else
      begin
         if (arvalid && arready)
         begin
            rd_pend_reg <= 1'b1;
            arready <= 1'b0;
            rd_addr <= araddr;
         end
         if (rd_en)
         begin
            rd_pend_reg <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_hit ? rd_data : 32'h0000_0000;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule : cpc_axil_port

// ---- hdl/cpc_pkg.sv ----
// Register map, field layout and carriers of the protection control block
package cpc_pkg;
   localparam int ADDR_W = 12;
   localparam logic [7:0] IDX_CFG = 8'hc2;
   localparam logic [7:0] IDX_CTL = 8'hc3;
   localparam logic [7:0] IDX_STS = 8'hc4;
   localparam logic [ADDR_W-1:0] ADDR_CFG = {2'b00, IDX_CFG, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CTL = {2'b00, IDX_CTL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STS = {2'b00, IDX_STS, 2'b00};
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_MASK = 8'h38;
   localparam int B_ENG_RST = 7;
   localparam int B_RSVD = 6;
   localparam int B_LIST_OK = 5;
   localparam int B_KEY_OK = 4;
   localparam int B_ENC_OFF = 3;
   localparam int B_ENC_ON = 2;
   localparam int B_AUTH_DIS = 1;
   localparam int B_AUTH_EN = 0;
   localparam int B_RPTR = 5;
   localparam int B_MODE_HI = 4;
   localparam int B_MODE_LO = 3;
   localparam int S_LIST_RDY = 2;
   localparam int S_KEY_RDY = 1;
   localparam int S_AUTHED = 0;
   localparam logic [1:0] ENC_ALWAYS = 2'b10;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [23:0] BLUE_RGB = 24'h0000ff;
   localparam logic [23:0] KS_SEED = 24'h5a5a5a;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } reg_wr_t;

   typedef struct packed {
      logic de;
      logic [23:0] rgb;
   } vid_t;

   typedef enum logic [2:0] {
      A_OFF = 3'b000,
      A_FETCH = 3'b001,
      A_KEY_WAIT = 3'b011,
      A_LIST_WAIT = 3'b010,
      A_DONE = 3'b110
   } auth_state_t;
endpackage : cpc_pkg

// ---- hdl/cpc_video_select.sv ----
// Video output selector: cipher stand-in, blue screen or pass-through
`timescale 1ns/1ps
module cpc_video_select
   import cpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire vid_t vid_in,
   input wire logic enc_en,
   input wire logic authed,
   output vid_t vid_out
);
   logic [23:0] ks_reg;

   // Keystream advances only on encrypted active pixels
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !authed)
         ks_reg <= KS_SEED;
      else if (enc_en && vid_in.de)
         ks_reg <= {ks_reg[22:0],
                    ks_reg[23] ^ ks_reg[22] ^ ks_reg[21] ^ ks_reg[16]};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         vid_out <= '0;
      else if (enc_en && authed)
         vid_out <= '{de: vid_in.de, rgb: vid_in.rgb ^ ks_reg};
      else if (enc_en)
         vid_out <= '{de: vid_in.de, rgb: BLUE_RGB};
      else
         vid_out <= vid_in;
   end
endmodule : cpc_video_select

// ---- sim/cpc_rx_model.sv ----
// Receiver-side model that drives the link status pins
`timescale 1ns/1ps
module cpc_rx_model
(
   input wire logic aclk,
   output logic key_fetched,
   output logic list_fetched,
   output logic link_lost
);
   initial
   begin
      key_fetched = 1'b0;
      list_fetched = 1'b0;
      link_lost = 1'b0;
   end

   // Level held n cycles; a long n is a slow receiver
   task automatic pulse(input int which, input int n);
      begin
         @(posedge aclk);
         case (which)
            0: key_fetched <= 1'b1;
            1: list_fetched <= 1'b1;
            default: link_lost <= 1'b1;
         endcase
         repeat (n) @(posedge aclk);
         key_fetched <= 1'b0;
         list_fetched <= 1'b0;
         link_lost <= 1'b0;
      end
   endtask : pulse
endmodule : cpc_rx_model

// ---- sim/tb_content_protect_control_reg.sv ----
// Self-checking bench of the protection control register
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      total_checks++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("mismatch at %0t: got %h want %h", $time, g, e); \
      end \
   end
module tb_content_protect_control_reg
   import cpc_pkg::*;
   ;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, authed_reg;
   logic key_fetched, list_fetched, link_lost;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   vid_t vid_in, vid_out;
   logic m_en, m_enc, m_key, m_list, m_alw;
   int n_errors = 0;
   int total_checks = 0;
   int seed = 32'h33dc9833;

   content_protect_control_reg content_protect_control_reg_inst (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .key_fetched,
      .list_fetched, .link_lost, .vid_in, .vid_out, .authed_reg
   );

   cpc_rx_model cpc_rx_model_inst (
      .aclk, .key_fetched, .list_fetched, .link_lost
   );

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic end_sim();
      begin
         $display("checks %0d mismatches %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask : end_sim

   task automatic tmo();
      begin
         n_errors++;
         $display("mismatch at %0t: no answer", $time);
         end_sim();
      end
   endtask : tmo

   // One AXI4-Lite write (w=1) or read (w=0), held until answered
   task automatic axi(input bit w, input logic [ADDR_W-1:0] a,
         input logic [7:0] wd, input logic [3:0] s,
         output logic [31:0] x, output logic [1:0] q);
      int n;
      logic got;
      begin
         got = 1'b0;
         x = '0;
         q = 2'b11;
         @(posedge aclk);
         if (w)
         begin
            awaddr <= a;
            awvalid <= 1'b1;
            wdata <= {24'($random(seed)), wd};
            wstrb <= s;
            wvalid <= 1'b1;
            bready <= 1'b1;
         end
         else
         begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
         end
         for (n = 0; n < 40 && !got; n++)
         begin
            @(posedge aclk);
            if (awready === 1'b1)
               awvalid <= 1'b0;
            if (wready === 1'b1)
               wvalid <= 1'b0;
            if (arready === 1'b1)
               arvalid <= 1'b0;
            if (bvalid === 1'b1 || rvalid === 1'b1)
            begin
               x = rdata;
               q = w ? bresp : rresp;
               bready <= 1'b0;
               rready <= 1'b0;
               got = 1'b1;
            end
         end
         if (!got)
            tmo();
      end
   endtask : axi

   // Register write plus update of the reference model
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      logic [31:0] x;
      logic [1:0] q;
      begin
         axi(1'b1, a, v, 4'h1, x, q);
         `CHK(q, RESP_OKAY)
         if (a == ADDR_CFG)
            m_alw = (v[B_MODE_HI:B_MODE_LO] == ENC_ALWAYS);
         else
         begin
            if (v[B_ENG_RST])
            begin
               m_en = 1'b0;
               m_key = 1'b0;
               m_list = 1'b0;
            end
            else if (v[B_AUTH_DIS])
               m_en = 1'b0;
            else if (v[B_AUTH_EN])
               m_en = 1'b1;
            if (v[B_KEY_OK])
               m_key = 1'b1;
            if (!m_alw)
               m_enc = v[B_ENC_ON] & ~v[B_ENC_OFF];
         end
      end
   endtask : wr

   task automatic cctl(input logic [7:0] k);
      logic [31:0] x;
      logic [31:0] e;
      logic [1:0] q;
      begin
         axi(1'b0, ADDR_CTL, 8'h00, 4'h0, x, q);
         e = {24'h0, 2'b00, m_list, m_key, 1'b0, m_enc | m_alw, 1'b0, m_en};
         x = x & {24'h0, k};
         e = e & {24'h0, k};
         `CHK(q, RESP_OKAY)
         `CHK(x, e)
      end
   endtask : cctl

   task automatic csts(input logic [31:0] e);
      logic [31:0] x;
      logic [1:0] q;
      begin
         axi(1'b0, ADDR_STS, 8'h00, 4'h0, x, q);
         `CHK(q, RESP_OKAY)
         `CHK(x, e)
      end
   endtask : csts

   task automatic wauth(input logic e);
      int n;
      begin
         for (n = 0; n < 40 && authed_reg !== e; n++)
            @(posedge aclk);
         if (authed_reg !== e)
            tmo();
         `CHK(authed_reg, e)
      end
   endtask : wauth

   // Mode 0 clear, 1 blue screen, 2 cipher at its seed
   task automatic vchk(input int m);
      vid_t v;
      vid_t e;
      begin
         v = 25'($random(seed));
         if (m == 2)
            v.de = 1'b0;
         e = v;
         if (m == 1)
            e.rgb = BLUE_RGB;
         if (m == 2)
            e.rgb = v.rgb ^ KS_SEED;
         @(posedge aclk);
         vid_in <= v;
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         `CHK(vid_out, e)
      end
   endtask : vchk

   initial
   begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      vid_in = '0;
      {m_en, m_enc, m_key, m_list, m_alw} = '0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      `CHK(authed_reg, 1'b0)
      cctl(8'hff);
      csts(32'h0);
      wr(ADDR_CTL, 8'h40);
      cctl(8'hff);
      axi(1'b1, ADDR_CTL, 8'h01, 4'h0, d, r);
      cctl(8'hff);
      wr(ADDR_CTL, 8'h01);
      cctl(8'hff);
      wr(ADDR_CTL, 8'h00);
      cctl(8'hff);
      $display("test reset_enable done");
      wr(ADDR_CTL, 8'h10);
      wr(ADDR_CTL, 8'h00);
      cctl(8'hff);
      cpc_rx_model_inst.pulse(0, 4);
      m_key = 1'b0;
      cctl(8'hff);
      csts(32'h2);
      `CHK(authed_reg, 1'b0)
      wr(ADDR_CTL, 8'h14);
      wauth(1'b1);
      csts(32'h1);
      vchk(2);
      $display("test key_auth done");
      wr(ADDR_CTL, 8'h08);
      cctl(8'h0f);
      `CHK(authed_reg, 1'b1)
      vchk(0);
      wr(ADDR_CTL, 8'h04);
      cpc_rx_model_inst.pulse(2, 3);
      wauth(1'b0);
      vchk(1);
      wr(ADDR_CTL, 8'h84);
      cctl(8'hff);
      wr(ADDR_CTL, 8'h00);
      wr(ADDR_CFG, 8'h10);
      axi(1'b0, ADDR_CFG, 8'h00, 4'h0, d, r);
      `CHK(d, 32'h10)
      cctl(8'hff);
      vchk(1);
      wr(ADDR_CTL, 8'h04);
      wr(ADDR_CFG, 8'h00);
      cctl(8'hff);
      $display("test encrypt done");
      wr(ADDR_CFG, 8'h20);
      wr(ADDR_CTL, 8'h01);
      cpc_rx_model_inst.pulse(0, 4);
      wr(ADDR_CTL, 8'h10);
      cpc_rx_model_inst.pulse(1, 6);
      `CHK(authed_reg, 1'b0)
      csts(32'h4);
      wr(ADDR_CTL, 8'h20);
      wauth(1'b1);
      cctl(8'h2f);
      wr(ADDR_CTL, 8'h01);
      wauth(1'b0);
      cctl(8'h2f);
      wr(ADDR_CTL, 8'h02);
      cctl(8'h2f);
      `CHK(authed_reg, 1'b0)
      axi(1'b1, 12'h000, 8'hff, 4'hf, d, r);
      `CHK(r, RESP_SLVERR)
      axi(1'b0, 12'h000, 8'h00, 4'h0, d, r);
      `CHK(r, RESP_SLVERR)
      `CHK(d, 32'h0)
      cctl(8'h2f);
      $display("test repeater_unmapped done");
      wr(ADDR_CTL, 8'h15);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      {m_en, m_enc, m_key, m_list, m_alw} = '0;
      @(negedge aclk);
      `CHK(vid_out, 25'h0)
      `CHK(authed_reg, 1'b0)
      cctl(8'hff);
      csts(32'h0);
      axi(1'b0, ADDR_CFG, 8'h00, 4'h0, d, r);
      `CHK(d, 32'h0)
      $display("test mid_reset done");
      end_sim();
   end
endmodule : tb_content_protect_control_reg
